// >>> irq_flag_pkg.sv
// Register map, field layout and reset values of the interrupt request flag block
package irq_flag_pkg;
	localparam logic [5:0] MAIN_FLAGS_OFS     = 6'h00;
	localparam logic [5:0] WAKE_FLAGS_OFS     = 6'h04;
	localparam logic [5:0] CONTROL_OFS        = 6'h08;
	localparam logic [5:0] IRQ_STATUS_OFS     = 6'h0C;
	localparam logic [5:0] IRQ_MASK_OFS       = 6'h10;
	localparam int         DT_BIT             = 7;
	localparam int         TA_BIT             = 6;
	localparam logic [7:0] MAIN_RSVD_ONES     = 8'h30;
	localparam logic [7:0] WAKE_RSVD_ONES     = 8'hC0;
	localparam logic [7:0] MAIN_FLAG_MASK     = 8'hCF;
	localparam logic [7:0] WAKE_FLAG_MASK     = 8'h3F;
	localparam logic [7:0] FLAGS_RESET        = 8'h00;
	localparam int         CTL_EXT_EDGE_LSB   = 0;
	localparam int         CTL_WAKE_EDGE_LSB  = 8;
	localparam int         CTL_EXT_FUNC_LSB   = 16;
	localparam int         CTL_WAKE_FUNC_LSB  = 20;
	localparam int         CTL_DT_ENABLE_BIT  = 26;
	localparam logic [31:0] CONTROL_RESET     = 32'h0000_0000;
	localparam logic [1:0] IRQ_MAIN_BIT_MASK  = 2'h3;
	localparam logic [1:0] RESP_OKAY          = 2'h0;
	localparam logic [1:0] RESP_SLVERR        = 2'h2;
endpackage

// >>> edge_sense.sv
// Per-pin selectable edge detector for the request pins
`timescale 1ns/10ps
module edge_sense
	import irq_flag_pkg::*;
#(
	parameter int WIDTH = 4
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             reset_i,
	// Pins and configuration
	input  wire logic [WIDTH-1:0] pin_i,
	input  wire logic [WIDTH-1:0] rising_i,
	input  wire logic [WIDTH-1:0] armed_i,
	// Detected edges
	output logic      [WIDTH-1:0] edge_o
);
	logic [WIDTH-1:0] last_reg;
	logic             primed_reg;

	// Prime one cycle after reset so a pin already high is not taken as an edge
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			last_reg   <= '0;
			primed_reg <= 1'b0;
		end else begin
			last_reg   <= pin_i;
			primed_reg <= 1'b1;
		end
	end

	// [R12] edge select
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			edge_o[i] = primed_reg && armed_i[i] &&
				(rising_i[i] ? (pin_i[i] && !last_reg[i]) : (!pin_i[i] && last_reg[i]));
		end
	end
endmodule

// >>> flag_bank.sv
// Bank of sticky request flags: hardware set, software write-zero clear
`timescale 1ns/10ps
module flag_bank
	import irq_flag_pkg::*;
#(
	parameter logic [7:0] FLAG_MASK = 8'hFF
) (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	// Events and software clear
	input  wire logic [7:0] set_i,
	input  wire logic       wr_i,
	input  wire logic [7:0] wdata_i,
	// Flags
	output logic      [7:0] flags_o
);
	logic [7:0] flags_reg;
	logic [7:0] flags_next;

	always_comb begin
		flags_next = flags_reg;
		// [R2] write zero clears, one keeps
		if (wr_i) begin
			flags_next = flags_reg & wdata_i;
		end
		// [R15] set wins over clear
		flags_next = (flags_next | set_i) & FLAG_MASK;
	end

	always_ff @(posedge clk_i) begin
		// [R11] flags clear at reset
		if (reset_i) begin
			flags_reg <= FLAGS_RESET;
		end else begin
			flags_reg <= flags_next;
		end
	end

	assign flags_o = flags_reg;
endmodule

// >>> irq_flag_regs.sv
// Interrupt request flag registers with AXI4-Lite access and summary interrupt
//
// How it works
// [R1] Sleep direct transition sets bit 7 when enabled
// [R2] Direct transition flag cleared by writing zero
// [R3] Timer overflow sets bit 6
// [R4] Timer flag cleared by writing zero
// [R5] Reserved bits read back as one
// [R6] External pin edge sets bits 3..0
// [R7] External pin flags cleared by writing zero
// [R8] Six wakeup flags in bits 5..0
// [R9] Wakeup pin edge sets its flag
// [R10] Wakeup flags cleared by writing zero
// [R11] All flags zero after reset
// [R12] Select bit: 0 falling, 1 rising
// [R13] Requests gated by pin or common enable
// [R14] Software masks before clearing flags or enables
// [R15] Writing one keeps; set beats clear
// [R16] Reserved writes ignored; flags drive request outputs
//
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
module irq_flag_regs
	import irq_flag_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	// AXI4-Lite write address
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_awaddr,
	// AXI4-Lite write data
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// AXI4-Lite write response
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// AXI4-Lite read address
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [31:0] s_axi_araddr,
	// AXI4-Lite read data
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// Event sources
	input  wire logic        sleep_direct_i,
	input  wire logic        timer_overflow_i,
	input  wire logic [3:0]  ext_request_pin_i,
	input  wire logic [5:0]  wakeup_pin_i,
	// Enables from the enable register outside this block
	input  wire logic [3:0]  ext_pin_enable_i,
	input  wire logic        wake_common_enable_i,
	// Request outputs
	output logic [7:0]       main_request_o,
	output logic [5:0]       wake_request_o,
	output logic             irq_o
);
	logic [7:0]  main_interrupt_flags;
	logic [7:0]  wakeup_interrupt_flags;
	logic [31:0] control_reg;
	logic [1:0]  irq_status_reg;
	logic [1:0]  irq_mask_reg;
	logic [31:0] awaddr_reg;
	logic        aw_held_reg;
	logic [31:0] wdata_reg;
	logic [3:0]  wstrb_reg;
	logic        w_held_reg;
	logic        do_write;
	logic [3:0]  ext_edge;
	logic [5:0]  wake_edge;
	logic [7:0]  main_set;
	logic [7:0]  wake_set;
	logic        wr_main;
	logic        wr_wake;
	logic [1:0]  prev_any_reg;
	logic [1:0]  any_flag;

	// Keep address bits 5..2 and zero bits 1..0 so the mask word does not alias the flag word
	function automatic logic [5:0] word_of(input logic [31:0] addr);
		return {addr[5:2], 2'b00};
	endfunction

	function automatic logic addr_ok(input logic [31:0] addr);
		logic [5:0] w;
		w = word_of(addr);
		return (addr[31:6] == '0) && (addr[1:0] == 2'h0) &&
			(w == MAIN_FLAGS_OFS || w == WAKE_FLAGS_OFS || w == CONTROL_OFS ||
			w == IRQ_STATUS_OFS || w == IRQ_MASK_OFS);
	endfunction

	// Write channel: address and data taken in either order
	assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
	assign do_write      = aw_held_reg && w_held_reg && !s_axi_bvalid;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			aw_held_reg <= 1'b0;
			awaddr_reg  <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_reg <= 1'b1;
			awaddr_reg  <= s_axi_awaddr;
		end else if (do_write) begin
			aw_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			w_held_reg <= 1'b0;
			wdata_reg  <= '0;
			wstrb_reg  <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_reg <= 1'b1;
			wdata_reg  <= s_axi_wdata;
			wstrb_reg  <= s_axi_wstrb;
		end else if (do_write) begin
			w_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= addr_ok(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Flag bytes live in lane 0; a write without that lane leaves them alone
	assign wr_main = do_write && addr_ok(awaddr_reg) && wstrb_reg[0] &&
		word_of(awaddr_reg) == MAIN_FLAGS_OFS;
	assign wr_wake = do_write && addr_ok(awaddr_reg) && wstrb_reg[0] &&
		word_of(awaddr_reg) == WAKE_FLAGS_OFS;

	// Control: edge selects, pin function and direct transition enable
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			control_reg <= CONTROL_RESET;
		end else if (do_write && addr_ok(awaddr_reg) &&
				word_of(awaddr_reg) == CONTROL_OFS) begin
			for (int b = 0; b < 4; b++) begin
				if (wstrb_reg[b]) begin
					control_reg[8*b +: 8] <= wdata_reg[8*b +: 8];
				end
			end
			control_reg[31:27] <= '0;
		end
	end

	// [R6] external pin edges, only when pin set for interrupt input
	edge_sense #(.WIDTH(4)) ext_sense (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.pin_i   (ext_request_pin_i),
		.rising_i(control_reg[CTL_EXT_EDGE_LSB +: 4]),
		.armed_i (control_reg[CTL_EXT_FUNC_LSB +: 4]),
		.edge_o  (ext_edge)
	);

	// [R9] wakeup pin edges, only when pin set for interrupt input
	edge_sense #(.WIDTH(6)) wake_sense (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.pin_i   (wakeup_pin_i),
		.rising_i(control_reg[CTL_WAKE_EDGE_LSB +: 6]),
		.armed_i (control_reg[CTL_WAKE_FUNC_LSB +: 6]),
		.edge_o  (wake_edge)
	);

	always_comb begin
		main_set = '0;
		// [R1] direct transition when enabled
		main_set[DT_BIT] = sleep_direct_i && control_reg[CTL_DT_ENABLE_BIT];
		// [R3] timer overflow
		main_set[TA_BIT] = timer_overflow_i;
		main_set[3:0]    = ext_edge;
		// [R8] six wakeup flags
		wake_set = {2'b00, wake_edge};
	end

	// [R4] [R7] write-zero clear of main flags
	flag_bank #(.FLAG_MASK(MAIN_FLAG_MASK)) main_bank (
		.clk_i  (clk_i),
		.reset_i(reset_i),
		.set_i  (main_set),
		.wr_i   (wr_main),
		.wdata_i(wdata_reg[7:0]),
		.flags_o(main_interrupt_flags)
	);

	// [R10] write-zero clear of wakeup flags
	flag_bank #(.FLAG_MASK(WAKE_FLAG_MASK)) wake_bank (
		.clk_i  (clk_i),
		.reset_i(reset_i),
		.set_i  (wake_set),
		.wr_i   (wr_wake),
		.wdata_i(wdata_reg[7:0]),
		.flags_o(wakeup_interrupt_flags)
	);

	// [R16] flags drive request lines
	always_comb begin
		main_request_o = main_interrupt_flags;
		// [R13] pin enable and common wakeup enable
		main_request_o[3:0] = main_interrupt_flags[3:0] & ext_pin_enable_i;
		wake_request_o = wakeup_interrupt_flags[5:0] & {6{wake_common_enable_i}};
	end

	// Summary events: a register turning non-empty sets its sticky status bit
	assign any_flag = {|wakeup_interrupt_flags, |main_interrupt_flags};

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			prev_any_reg   <= '0;
			irq_status_reg <= '0;
		end else begin
			prev_any_reg <= any_flag;
			// Set wins over a write-one clear in the same cycle
			irq_status_reg <= (irq_status_reg &
				~((do_write && addr_ok(awaddr_reg) && wstrb_reg[0] &&
				word_of(awaddr_reg) == IRQ_STATUS_OFS) ? wdata_reg[1:0] : 2'b00)) |
				(any_flag & ~prev_any_reg);
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			irq_mask_reg <= '0;
		end else if (do_write && addr_ok(awaddr_reg) && wstrb_reg[0] &&
				word_of(awaddr_reg) == IRQ_MASK_OFS) begin
			irq_mask_reg <= wdata_reg[1:0] & IRQ_MAIN_BIT_MASK;
		end
	end

	assign irq_o = |(irq_status_reg & irq_mask_reg);

	// Read channel: one read at a time, answer one cycle after the address
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			case (word_of(s_axi_araddr))
				// [R5] reserved bits read as one
				MAIN_FLAGS_OFS: s_axi_rdata <= {24'h0, main_interrupt_flags | MAIN_RSVD_ONES};
				WAKE_FLAGS_OFS: s_axi_rdata <= {24'h0, wakeup_interrupt_flags | WAKE_RSVD_ONES};
				CONTROL_OFS:    s_axi_rdata <= control_reg;
				IRQ_STATUS_OFS: s_axi_rdata <= {30'h0, irq_status_reg};
				IRQ_MASK_OFS:   s_axi_rdata <= {30'h0, irq_mask_reg};
				default:        s_axi_rdata <= 32'h0000_0000;
			endcase
			if (!addr_ok(s_axi_araddr)) begin
				s_axi_rdata <= 32'h0000_0000;
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// >>> irq_flag_regs_sva.sv
// Assertions on the request outputs of the flag block
`timescale 1ns/10ps
module irq_flag_regs_sva (
	// Clock and bus
	input wire logic        clk_i,
	input wire logic        reset_i,
	input wire logic        s_axi_bvalid,
	// Events, enables and requests
	input wire logic        timer_overflow_i,
	input wire logic [3:0]  ext_pin_enable_i,
	input wire logic        wake_common_enable_i,
	input wire logic [7:0]  main_request_o,
	input wire logic [5:0]  wake_request_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	property p_ta_set; timer_overflow_i |=> main_request_o[6]; endproperty
	a_ta_set: assert property (p_ta_set) else $error("timer flag not set");
	property p_dt_clr; $fell(main_request_o[7]) |-> $rose(s_axi_bvalid); endproperty
	a_dt_clr: assert property (p_dt_clr) else $error("direct flag lost");
	property p_ta_clr; $fell(main_request_o[6]) |-> $rose(s_axi_bvalid); endproperty
	a_ta_clr: assert property (p_ta_clr) else $error("timer flag lost");
	// Enable held steady, so a falling request can only be a write
	property p_ext_clr; (ext_pin_enable_i & $past(ext_pin_enable_i) & $past(main_request_o[3:0])
		& ~main_request_o[3:0]) != 4'h0 |-> $rose(s_axi_bvalid); endproperty
	a_ext_clr: assert property (p_ext_clr) else $error("pin flag lost");
	property p_wk_clr; wake_common_enable_i && $past(wake_common_enable_i)
		&& ($past(wake_request_o) & ~wake_request_o) != 6'h00 |-> $rose(s_axi_bvalid); endproperty
	a_wk_clr: assert property (p_wk_clr) else $error("wake flag lost");
	property p_rsvd; main_request_o[5:4] == 2'h0; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved request set");
	property p_ext_gate; (main_request_o[3:0] & ~ext_pin_enable_i) == 4'h0; endproperty
	a_ext_gate: assert property (p_ext_gate) else $error("pin request not gated");
	property p_wk_gate; !wake_common_enable_i |-> wake_request_o == 6'h00; endproperty
	a_wk_gate: assert property (p_wk_gate) else $error("wake request not gated");
	property p_rst; $fell(reset_i) |-> main_request_o == 8'h00 && wake_request_o == 6'h00;
	endproperty
	a_rst: assert property (p_rst) else $error("flags not clear after reset");
endmodule
bind irq_flag_regs irq_flag_regs_sva i_sva (.clk_i, .reset_i, .s_axi_bvalid, .timer_overflow_i,
	.ext_pin_enable_i, .wake_common_enable_i, .main_request_o, .wake_request_o);

// >>> cpu_bus_model.sv
// Register bus master standing in for the CPU
`timescale 1ns/10ps
module cpu_bus_model (
	// Clock
	input  wire logic        clk_i,
	// Write channels
	output logic             s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic [31:0]      s_axi_awaddr,
	output logic             s_axi_wvalid,
	input  wire logic        s_axi_wready,
	output logic [31:0]      s_axi_wdata,
	output logic [3:0]       s_axi_wstrb,
	input  wire logic        s_axi_bvalid,
	output logic             s_axi_bready,
	input  wire logic [1:0]  s_axi_bresp,
	// Read channels
	output logic             s_axi_arvalid,
	input  wire logic        s_axi_arready,
	output logic [31:0]      s_axi_araddr,
	input  wire logic        s_axi_rvalid,
	output logic             s_axi_rready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp
);
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
		s_axi_wstrb = 4'hF;
	end
	// Released payloads are inverted so a stale value is never mistaken for a live one
	task automatic bus_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk_i);
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr <= a;
		s_axi_wvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_bready <= 1'b1;
		fork
			begin
				do @(posedge clk_i); while (s_axi_awready !== 1'b1);
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~a;
			end
			begin
				do @(posedge clk_i); while (s_axi_wready !== 1'b1);
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~d;
			end
		join
		while (s_axi_bvalid !== 1'b1) @(posedge clk_i);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic bus_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_i);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr <= a;
		s_axi_rready <= 1'b1;
		do @(posedge clk_i); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		s_axi_araddr <= ~a;
		do @(posedge clk_i); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
endmodule

// >>> tb_top.sv
// Self-checking bench for the interrupt request flag block
`timescale 1ns/10ps
module tb_top
	import irq_flag_pkg::*;
;
	localparam logic [31:0] M0 = {24'h0, MAIN_RSVD_ONES};
	localparam logic [31:0] W0 = {24'h0, WAKE_RSVD_ONES};
	localparam logic [31:0] AM = {26'h0, MAIN_FLAGS_OFS};
	localparam logic [31:0] AW = {26'h0, WAKE_FLAGS_OFS};
	localparam logic [31:0] AC = {26'h0, CONTROL_OFS};
	localparam logic [31:0] AS = {26'h0, IRQ_STATUS_OFS};
	localparam logic [31:0] AK = {26'h0, IRQ_MASK_OFS};
	logic        clk_i = 1'b0, reset_i = 1'b1;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb, ext_request_pin_i = 4'h5, ext_pin_enable_i = 4'h3;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic        sleep_direct_i = 1'b0, timer_overflow_i = 1'b0, wake_common_enable_i = 1'b0;
	logic [5:0]  wakeup_pin_i = 6'h00, wake_request_o;
	logic [7:0]  main_request_o;
	logic        irq_o;
	int          errors = 0, n_checks = 0, cycles = 0;
	always #50 clk_i = ~clk_i;
	irq_flag_regs i_dut (.clk_i, .reset_i, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
		.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
		.s_axi_rready, .s_axi_rdata, .s_axi_rresp, .sleep_direct_i, .timer_overflow_i,
		.ext_request_pin_i, .wakeup_pin_i, .ext_pin_enable_i, .wake_common_enable_i,
		.main_request_o, .wake_request_o, .irq_o);
	cpu_bus_model i_cpu (.clk_i, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
		.s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
		.s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
		.s_axi_rdata, .s_axi_rresp);
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rc(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
		i_cpu.bus_read(a, rd, rsp);
		chk("rdata", exp, rd);
		chk("rresp", {30'h0, er}, {30'h0, rsp});
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		i_cpu.bus_write(a, d, rsp);
		chk("bresp", {30'h0, RESP_OKAY}, {30'h0, rsp});
	endtask
	task automatic pins(input logic [3:0] e, input logic [5:0] w);
		@(posedge clk_i);
		ext_request_pin_i <= e;
		wakeup_pin_i <= w;
		repeat (3) @(posedge clk_i);
	endtask
	task automatic pulse(input logic t, input logic s);
		@(posedge clk_i);
		timer_overflow_i <= t;
		sleep_direct_i <= s;
		@(posedge clk_i);
		timer_overflow_i <= 1'b0;
		sleep_direct_i <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask
	task automatic wrap_up;
		$display("Checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			wrap_up();
		end
	end
	initial begin
		repeat (10) @(posedge clk_i);
		reset_i <= 1'b0;
		rc(AM, M0, RESP_OKAY);
		rc(AW, W0, RESP_OKAY);
		rc(AC, CONTROL_RESET, RESP_OKAY);
		rc(32'h0000_0020, 32'h0, RESP_SLVERR);
		// Pins not yet in interrupt function, sleep not enabled
		pins(4'hA, 6'h3F);
		pulse(1'b1, 1'b1);
		rc(AM, M0 | 32'h40, RESP_OKAY);
		rc(AW, W0, RESP_OKAY);
		wr(AM, 32'hFF);
		rc(AM, M0 | 32'h40, RESP_OKAY);
		wr(AM, 32'h00);
		rc(AM, M0, RESP_OKAY);
		wr(AC, 32'h1 << CTL_DT_ENABLE_BIT);
		pulse(1'b0, 1'b1);
		rc(AM, M0 | 32'h80, RESP_OKAY);
		wr(AM, 32'h7F);
		rc(AM, M0, RESP_OKAY);
		// Overflow held high across a clearing write
		@(posedge clk_i);
		timer_overflow_i <= 1'b1;
		wr(AM, 32'h00);
		timer_overflow_i <= 1'b0;
		rc(AM, M0 | 32'h40, RESP_OKAY);
		wr(AM, 32'h00);
		// Pins 1 and 3 rising, 0 and 2 falling, all armed; wake pins all rising
		wr(AC, 32'h03FF_3F0A);
		pins(4'h5, 6'h00);
		rc(AM, M0, RESP_OKAY);
		rc(AW, W0, RESP_OKAY);
		pins(4'hA, 6'h3F);
		rc(AM, M0 | 32'h0F, RESP_OKAY);
		rc(AW, W0 | 32'h3F, RESP_OKAY);
		chk("main_req", 32'h03, {24'h0, main_request_o});
		ext_pin_enable_i <= 4'hC;
		@(posedge clk_i);
		chk("main_req", 32'h0C, {24'h0, main_request_o});
		chk("wake_req", 32'h0, {26'h0, wake_request_o});
		wake_common_enable_i <= 1'b1;
		@(posedge clk_i);
		chk("wake_req", 32'h3F, {26'h0, wake_request_o});
		wr(AM, 32'hFE);
		rc(AM, M0 | 32'h0E, RESP_OKAY);
		chk("main_req", 32'h0C, {24'h0, main_request_o});
		wr(AM, 32'h00);
		rc(AM, M0, RESP_OKAY);
		wr(AW, 32'h3E);
		rc(AW, W0 | 32'h3E, RESP_OKAY);
		wr(AW, 32'h00);
		rc(AW, W0, RESP_OKAY);
		chk("irq", 32'h0, {31'h0, irq_o});
		rc(AS, 32'h3, RESP_OKAY);
		wr(AK, 32'h3);
		chk("irq", 32'h1, {31'h0, irq_o});
		// Status cleared while masked off first
		wr(AK, 32'h0);
		wr(AS, 32'h3);
		rc(AS, 32'h0, RESP_OKAY);
		wr(AK, 32'h3);
		chk("irq", 32'h0, {31'h0, irq_o});
		wrap_up();
	end
endmodule
